// *** adcc_params.svh ***
// Constants for the converter control block: offsets, fields, reset values, timing.
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH
// Register indices; byte address is four times the index.
`define ADCC_IDX_RESULT_HIGH 10'h09c
`define ADCC_IDX_RESULT_LOW 10'h09d
`define ADCC_IDX_CONTROL_ZERO 10'h09e
`define ADCC_IDX_CONFIG 10'h09f
`define ADCC_IDX_IRQ_STATUS 10'h0a0
`define ADCC_IDX_IRQ_ENABLE 10'h0a1
`define ADCC_IDX_IRQ_CLEAR 10'h0a2
// Field positions.
`define ADCC_CFG_JUSTIFY 7
`define ADCC_CFG_REF_HI 6
`define ADCC_CFG_REF_LO 4
`define ADCC_C0_POWER 0
`define ADCC_C0_GO 2
`define ADCC_C0_CHAN_HI 5
`define ADCC_C0_CHAN_LO 3
`define ADCC_C0_CLK_HI 7
`define ADCC_C0_CLK_LO 6
`define ADCC_IE_CONV 0
`define ADCC_IE_PERIPH 1
`define ADCC_IE_GLOBAL 2
// Reset values.
`define ADCC_CONFIG_RESET 8'h00
`define ADCC_CONTROL_RESET 8'h00
`define ADCC_ENABLE_RESET 3'h0
// Conversion timing: index of the last conversion-clock period, and mclk cycles per period.
`define ADCC_CONV_TADS 4'hc
`define ADCC_SAMPLE_TAD 4'h0
`define ADCC_TAD_DIV_0 8'h02
`define ADCC_TAD_DIV_1 8'h08
`define ADCC_TAD_DIV_2 8'h20
`define ADCC_TAD_DIV_3 8'h40
// Result width and trial start value.
`define ADCC_RES_W 12
`define ADCC_SAR_START 12'h800
`define ADCC_BIT_TOP 4'hb
// Bus responses.
`define ADCC_RESP_OKAY 2'h0
`define ADCC_RESP_SLVERR 2'h2
`endif

// *** adcc_pkg.sv ***
// Types for the converter control block.
`default_nettype none
package adcc_pkg;
    typedef enum logic [0:0] {ADCC_IDLE, ADCC_CONVERT} adcc_state_t;
endpackage : adcc_pkg
`default_nettype wire

// *** adcc_top.sv ***
// Successive-approximation converter control with an AXI4-Lite register slave.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "adcc_params.svh"
// ============================================================
module adcc_top
    import adcc_pkg::*;
(
    input wire logic mclk, // 100 MHz clock
    input wire logic reset, // synchronous, active high
    input wire logic [11:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [11:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic comp_in, // comparator: input at or above trial level
    output logic [11:0] trial_code, // trial code to the analog stage
    output logic sample_hold, // high while the input is sampled
    output logic converter_power_on, // analog power enable
    output logic [2:0] channel_select, // analog input channel
    output logic [2:0] reference_select, // reference pair select
    output logic irq // conversion-done interrupt request
);
    // ============================================================
    // Register bus
    logic [11:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic aw_full;
    logic w_full;
    logic next_aw_full;
    logic next_w_full;
    logic do_write;
    logic [9:0] wr_idx;
    logic wr_ok;

    function automatic logic mapped(input logic [9:0] idx);
        mapped = (idx >= `ADCC_IDX_RESULT_HIGH) && (idx <= `ADCC_IDX_IRQ_CLEAR);
    endfunction : mapped

    assign do_write = aw_full && w_full && !s_axi_bvalid;
    assign wr_idx = aw_addr[11:2];
    assign wr_ok = do_write && w_lane0 && mapped(wr_idx);

    always_comb
    begin
        next_aw_full = aw_full;
        next_w_full = w_full;
        if (s_axi_awvalid && s_axi_awready)
            next_aw_full = 1'b1;
        if (s_axi_wvalid && s_axi_wready)
            next_w_full = 1'b1;
        if (do_write)
        begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            s_axi_awready <= !next_aw_full;
            s_axi_wready <= !next_w_full;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (s_axi_awvalid && s_axi_awready)
            aw_addr <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_byte <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADCC_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(wr_idx) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ============================================================
    // Registers
    logic [7:0] config_reg;
    logic [1:0] clk_sel;
    logic go_done;
    logic done_flag;
    logic [2:0] irq_enable;
    logic [7:0] result_high;
    logic [7:0] result_low;
    logic wr_config;
    logic wr_control;
    logic start;
    logic abort;
    logic finish;
    adcc_state_t state;
    localparam logic [7:0] control_reset = `ADCC_CONTROL_RESET;
    localparam logic [7:0] config_reset = `ADCC_CONFIG_RESET;

    assign wr_config = wr_ok && (wr_idx == `ADCC_IDX_CONFIG);
    assign wr_control = wr_ok && (wr_idx == `ADCC_IDX_CONTROL_ZERO);
    // Power must already be on from an earlier write for a start to take.
    assign start = wr_control && w_byte[`ADCC_C0_GO] && converter_power_on
        && w_byte[`ADCC_C0_POWER] && (state == ADCC_IDLE);
    assign abort = (state == ADCC_CONVERT) && wr_control
        && (!w_byte[`ADCC_C0_GO] || !w_byte[`ADCC_C0_POWER]);

    always_ff @(posedge mclk)
    begin
        if (reset)
            config_reg <= `ADCC_CONFIG_RESET;
        else if (wr_config)
            config_reg <= w_byte;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            converter_power_on <= control_reset[`ADCC_C0_POWER];
            channel_select <= control_reset[`ADCC_C0_CHAN_HI:`ADCC_C0_CHAN_LO];
            clk_sel <= control_reset[`ADCC_C0_CLK_HI:`ADCC_C0_CLK_LO];
        end
        else if (wr_control)
        begin
            converter_power_on <= w_byte[`ADCC_C0_POWER];
            channel_select <= w_byte[`ADCC_C0_CHAN_HI:`ADCC_C0_CHAN_LO];
            clk_sel <= w_byte[`ADCC_C0_CLK_HI:`ADCC_C0_CLK_LO];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            reference_select <= config_reset[`ADCC_CFG_REF_HI:`ADCC_CFG_REF_LO];
        else
            reference_select <= config_reg[`ADCC_CFG_REF_HI:`ADCC_CFG_REF_LO];
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            go_done <= 1'b0;
        else if (start)
            go_done <= 1'b1;
        else if (finish || abort)
            go_done <= 1'b0;
    end

    // ============================================================
    // Conversion sequencer
    logic comp_meta;
    logic comp_sync;
    logic [7:0] tad_len;
    logic [7:0] div_cnt;
    logic [3:0] tad_cnt;
    logic [3:0] bit_idx;
    logic tad_end;

    always_ff @(posedge mclk)
    begin
        comp_meta <= comp_in;
        comp_sync <= comp_meta;
    end

    always_comb
    begin
        case (clk_sel)
            2'h0: tad_len = `ADCC_TAD_DIV_0;
            2'h1: tad_len = `ADCC_TAD_DIV_1;
            2'h2: tad_len = `ADCC_TAD_DIV_2;
            default: tad_len = `ADCC_TAD_DIV_3;
        endcase
    end

    assign tad_end = (state == ADCC_CONVERT) && (div_cnt == tad_len - 8'h01);
    assign finish = tad_end && (tad_cnt == `ADCC_CONV_TADS) && !abort;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state <= ADCC_IDLE;
            div_cnt <= 8'h00;
            tad_cnt <= 4'h0;
            bit_idx <= `ADCC_BIT_TOP;
            trial_code <= 12'h000;
            sample_hold <= 1'b0;
        end
        else
        begin
            case (state)
                ADCC_IDLE:
                begin
                    if (start)
                    begin
                        state <= ADCC_CONVERT;
                        div_cnt <= 8'h00;
                        tad_cnt <= `ADCC_SAMPLE_TAD;
                        bit_idx <= `ADCC_BIT_TOP;
                        trial_code <= `ADCC_SAR_START;
                        sample_hold <= 1'b1;
                    end
                end
                default:
                begin
                    if (abort || finish)
                    begin
                        state <= ADCC_IDLE;
                        sample_hold <= 1'b0;
                    end
                    else if (tad_end)
                    begin
                        div_cnt <= 8'h00;
                        tad_cnt <= tad_cnt + 4'h1;
                        sample_hold <= 1'b0;
                        // One result bit is resolved at the end of each period after sampling.
                        if (tad_cnt != `ADCC_SAMPLE_TAD)
                        begin
                            if (!comp_sync)
                                trial_code[bit_idx] <= 1'b0;
                            if (bit_idx != 4'h0)
                            begin
                                trial_code[bit_idx - 4'h1] <= 1'b1;
                                bit_idx <= bit_idx - 4'h1;
                            end
                        end
                    end
                    else
                        div_cnt <= div_cnt + 8'h01;
                end
            endcase
        end
    end

    // ============================================================
    // Result registers
    logic [11:0] final_code;

    always_comb
    begin
        final_code = trial_code;
        if (!comp_sync)
            final_code[0] = 1'b0;
    end

    // No reset branch: the result pair keeps its contents across any reset.
    // A reset edge also blocks a load, so a conversion cut by reset leaves no result.
    always_ff @(posedge mclk)
    begin
        if (!reset && (finish || abort))
        begin
            if (config_reg[`ADCC_CFG_JUSTIFY])
            begin
                result_high <= {4'h0, (finish ? final_code[11:8] : trial_code[11:8])};
                result_low <= finish ? final_code[7:0] : trial_code[7:0];
            end
            else
            begin
                result_high <= finish ? final_code[11:4] : trial_code[11:4];
                result_low <= {(finish ? final_code[3:0] : trial_code[3:0]), 4'h0};
            end
        end
    end

    // ============================================================
    // Interrupt
    logic clr_done;

    assign clr_done = wr_ok && (wr_idx == `ADCC_IDX_IRQ_CLEAR) && w_byte[0];

    always_ff @(posedge mclk)
    begin
        if (reset)
            done_flag <= 1'b0;
        else if (finish)
            done_flag <= 1'b1;
        else if (clr_done)
            done_flag <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            irq_enable <= `ADCC_ENABLE_RESET;
        else if (wr_ok && (wr_idx == `ADCC_IDX_IRQ_ENABLE))
            irq_enable <= w_byte[2:0];
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= done_flag && (&irq_enable);
    end

    // ============================================================
    // Read channel
    logic [7:0] rd_byte;
    logic [9:0] rd_idx;

    assign rd_idx = s_axi_araddr[11:2];

    always_comb
    begin
        rd_byte = 8'h00;
        if (rd_idx == `ADCC_IDX_RESULT_HIGH)
            rd_byte = result_high;
        else if (rd_idx == `ADCC_IDX_RESULT_LOW)
            rd_byte = result_low;
        else if (rd_idx == `ADCC_IDX_CONTROL_ZERO)
            rd_byte = {clk_sel, channel_select, go_done, 1'b0, converter_power_on};
        else if (rd_idx == `ADCC_IDX_CONFIG)
            rd_byte = config_reg;
        else if (rd_idx == `ADCC_IDX_IRQ_STATUS)
            rd_byte = {7'h00, done_flag};
        else if (rd_idx == `ADCC_IDX_IRQ_ENABLE)
            rd_byte = {5'h00, irq_enable};
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ADCC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= mapped(rd_idx) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
        else
            s_axi_arready <= 1'b1;
    end
endmodule : adcc_top
`default_nettype wire

// *** adcc_analog_model.sv ***
// Behavioural analog stage: sample-and-hold plus comparator for the converter control.
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Analog stage model
module adcc_analog_model (
    input wire logic mclk, // clock
    input wire logic [11:0] level, // analog input expressed as a code
    input wire logic sample_hold, // sampling window
    input wire logic [11:0] trial_code, // trial level
    output logic comp_in // high while the held input is at or above the trial
);
    logic [11:0] held;
    // The held level only follows the input inside the sampling window.
    always_ff @(posedge mclk)
    begin
        if (sample_hold)
            held <= level;
    end
    assign comp_in = (held >= trial_code);
endmodule : adcc_analog_model
`default_nettype wire

// *** adcc_assertions.sv ***
// Concurrent checks on the converter control ports.
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Port checker
module adcc_checker (
    input wire logic mclk, // clock
    input wire logic reset, // synchronous reset
    input wire logic s_axi_arvalid, // read address valid
    input wire logic s_axi_arready, // read address ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic s_axi_bvalid, // write response valid
    input wire logic [11:0] trial_code, // trial code
    input wire logic sample_hold, // sampling window
    input wire logic converter_power_on, // analog power
    input wire logic irq // interrupt request
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    a_reset_quiet:
        assert property (disable iff (1'b0) reset |=> !converter_power_on && !sample_hold
            && !irq && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs active after reset");
    a_sample_start:
        assert property ($rose(sample_hold) |-> trial_code == 12'h800)
        else $error("first trial is not mid scale");
    a_sample_len:
        assert property ($rose(sample_hold) |=> sample_hold) else $error("sampling too short");
    a_sample_powered:
        assert property (sample_hold |-> converter_power_on) else $error("sampling while off");
    a_trial_steady:
        assert property (sample_hold && $past(sample_hold) |-> $stable(trial_code))
        else $error("trial moved while sampling");
    a_read_answer:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");
    a_read_single:
        assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data held after handshake");
    a_rdata_upper:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
endmodule : adcc_checker
bind adcc_top adcc_checker chk (.mclk(mclk), .reset(reset), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid), .trial_code(trial_code),
    .sample_hold(sample_hold), .converter_power_on(converter_power_on), .irq(irq));
`default_nettype wire

// *** adcc_top_tb_top.sv ***
// Register-level testbench for the converter control block.
`timescale 1ns/10ps
`default_nettype none
`include "adcc_params.svh"
// ============================================================
// Testbench top
module adcc_top_tb_top;
    localparam logic [11:0] adr_hi = {`ADCC_IDX_RESULT_HIGH, 2'b00};
    localparam logic [11:0] adr_lo = {`ADCC_IDX_RESULT_LOW, 2'b00};
    localparam logic [11:0] adr_c0 = {`ADCC_IDX_CONTROL_ZERO, 2'b00};
    localparam logic [11:0] adr_cfg = {`ADCC_IDX_CONFIG, 2'b00};
    localparam logic [11:0] adr_st = {`ADCC_IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] adr_en = {`ADCC_IDX_IRQ_ENABLE, 2'b00};
    localparam logic [11:0] adr_clr = {`ADCC_IDX_IRQ_CLEAR, 2'b00};
    localparam int conv_len = 13 * `ADCC_TAD_DIV_1;
    logic mclk = 1'b0, reset = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, level = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    // Both response readies stay high all run, so an answer is taken at the edge it is seen.
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic comp_in, sample_hold, converter_power_on, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [11:0] trial_code;
    logic [2:0] channel_select, reference_select;
    logic [7:0] d;
    int errors = 0, comparisons = 0, cycles = 0;
    adcc_top dut (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .comp_in, .trial_code, .sample_hold, .converter_power_on, .channel_select,
        .reference_select, .irq);
    adcc_analog_model ana (.mclk, .level, .sample_hold, .trial_code, .comp_in);
    initial forever #5 mclk = ~mclk;
    task automatic complete_run;
        if (errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Address and data are offered together; each is dropped once its ready is seen.
    task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever
        begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        chk(s_axi_bresp, er);
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [7:0] v, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever
        begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        v = s_axi_rdata[7:0];
        chk(s_axi_rresp, er);
    endtask : rd
    task automatic rc(input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v, `ADCC_RESP_OKAY);
        chk(v, exp);
    endtask : rc
    // Go reads high until just before the 13th period ends and low just after it.
    task automatic conv(input logic [11:0] lv, input logic [7:0] hi, input logic [7:0] lo);
        level <= lv;
        wr(adr_c0, 8'h45, `ADCC_RESP_OKAY);
        rc(adr_c0, 8'h45);
        repeat (conv_len - 8) @(posedge mclk);
        rc(adr_c0, 8'h45);
        repeat (8) @(posedge mclk);
        rc(adr_c0, 8'h41);
        rc(adr_st, 8'h01);
        rc(adr_hi, hi);
        rc(adr_lo, lo);
    endtask : conv
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            complete_run();
        end
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        rc(adr_cfg, `ADCC_CONFIG_RESET);
        rc(adr_c0, `ADCC_CONTROL_RESET);
        rd(12'h000, d, `ADCC_RESP_SLVERR);
        chk(d, 8'h00);
        wr(12'h000, 8'hff, `ADCC_RESP_SLVERR);
        for (int i = 0; i < 8; i++)
        begin
            wr(adr_cfg, {1'b1, i[2:0], 4'h0}, `ADCC_RESP_OKAY);
            @(posedge mclk);
            chk(reference_select, i[2:0]);
        end
        wr(adr_c0, 8'h45, `ADCC_RESP_OKAY);
        rc(adr_c0, 8'h41);
        wr(adr_c0, 8'h69, `ADCC_RESP_OKAY);
        chk(channel_select, 3'h5);
        rc(adr_c0, 8'h69);
        wr(adr_c0, 8'h41, `ADCC_RESP_OKAY);
        wr(adr_en, 8'h07, `ADCC_RESP_OKAY);
        conv(12'ha5c, 8'h0a, 8'h5c);
        chk(irq, 1'b1);
        wr(adr_en, 8'h00, `ADCC_RESP_OKAY);
        wr(adr_clr, 8'h01, `ADCC_RESP_OKAY);
        rc(adr_st, 8'h00);
        wr(adr_cfg, 8'h00, `ADCC_RESP_OKAY);
        conv(12'h3c7, 8'h3c, 8'h70);
        chk(irq, 1'b0);
        wr(adr_clr, 8'h01, `ADCC_RESP_OKAY);
        wr(adr_cfg, 8'h80, `ADCC_RESP_OKAY);
        level <= 12'h9ff;
        wr(adr_c0, 8'h45, `ADCC_RESP_OKAY);
        repeat (50) @(posedge mclk);
        wr(adr_c0, 8'h41, `ADCC_RESP_OKAY);
        rc(adr_c0, 8'h41);
        rc(adr_st, 8'h00);
        rc(adr_hi, 8'h09);
        rc(adr_lo, 8'hc0);
        wr(adr_c0, 8'h45, `ADCC_RESP_OKAY);
        repeat (20) @(posedge mclk);
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        chk(converter_power_on, 1'b0);
        rc(adr_c0, 8'h00);
        rc(adr_hi, 8'h09);
        complete_run();
    end
endmodule : adcc_top_tb_top
`default_nettype wire
